/* File: verilog/pos_pkg.sv */
// Purpose: shared constants and types for the presence output sequencer
// Assumes: 10 MHz mclk; times configured in seconds or milliseconds
// Notes:   level codes are byte values already encoded from percentages
package pos_pkg;

	// -----------------------------------------------------------------
	// clock and time base
	// -----------------------------------------------------------------
	localparam int CLK_HZ        = 10000000;         // mclk rate
	localparam int MS_NS         = 1000000;          // one millisecond in ns
	localparam int CLK_NS        = 1000000000 / CLK_HZ;
	localparam int CYC_PER_MS    = MS_NS / CLK_NS;   // cycles in one millisecond
	localparam int MS_PER_S      = 1000;             // milliseconds per second

	// -----------------------------------------------------------------
	// configured time limits
	// -----------------------------------------------------------------
	localparam logic [15:0] CYC_MIN_S   = 16'h000a; // cyclic period floor, 10 s
	localparam logic [15:0] STAGE_MIN_S = 16'h0005; // stage stay floor, 5 s
	localparam logic [15:0] LIGHT_MIN_S = 16'h000a; // light-on floor, 10 s
	localparam logic [15:0] TIME_MAX_S  = 16'hffff; // 18:12:15 ceiling
	localparam logic [15:0] SAFE_MIN_MS = 16'h0064; // safety floor, 0.100 s
	localparam logic [15:0] SAFE_MAX_MS = 16'hea5f; // safety ceiling, 59.999 s
	localparam logic [15:0] CYC_DEF_S   = 16'h001e; // default cyclic period, 30 s

	// -----------------------------------------------------------------
	// value encodings
	// -----------------------------------------------------------------
	localparam logic [7:0] LEVEL_FULL = 8'hff;  // 100 %
	localparam logic [7:0] LEVEL_99   = 8'hfc;  // 99 %
	localparam logic [7:0] LEVEL_OFF  = 8'h00;  // 0 %, off code

	// send selection
	typedef enum logic [1:0] {
		POS_SEND_BOTH,
		POS_SEND_ON,
		POS_SEND_OFF
	} pos_send_t;

	// static configuration bundle
	typedef struct packed {
		pos_send_t   send_sel;    // which edges produce telegrams
		logic        byte_mode;   // 0: 1-bit value, 1: 1-byte value
		logic [7:0]  on_val;      // switch-on value (bit 0 in 1-bit mode)
		logic [7:0]  off_val;     // switch-off value
		logic        on_cyclic;   // repeat switch-on value
		logic        off_cyclic;  // repeat switch-off value
		logic [15:0] cyc_s;       // cyclic period, seconds
		logic        three_stage; // dim down through A, B, C
		logic [15:0] stay_a_s;    // stage stay times, seconds
		logic [15:0] stay_b_s;
		logic [15:0] stay_c_s;
		logic [7:0]  lvl_a;       // stage levels, byte codes
		logic [7:0]  lvl_b;
		logic [7:0]  lvl_c;
		logic [15:0] light_s;     // light-on delay, seconds
		logic [15:0] safe_ms;     // safety time, milliseconds
	} pos_cfg_t;

	// outgoing telegram
	typedef struct packed {
		logic       byte_mode;    // width of the value
		logic [7:0] value;        // value, bit 0 only in 1-bit mode
	} pos_tel_t;

endpackage : pos_pkg

/* File: verilog/pos_tick.sv */
// Purpose: millisecond and second tick generator
// Assumes: mclk at the package rate
// Notes:   ticks are one-cycle pulses; seconds are aligned to millisecond ticks
`timescale 1ns/1ns
module pos_tick
	import pos_pkg::*;
#(
	parameter int TICK_DIV = CYC_PER_MS  // mclk cycles per millisecond tick
)
(
	// clock and reset
	input  wire logic mclk,
	input  wire logic rstn,
	// ticks
	output logic      tick_ms,
	output logic      tick_s
);

	// -----------------------------------------------------------------
	// dividers
	// -----------------------------------------------------------------
	logic [15:0] cyc_cnt;   // cycles inside a millisecond
	logic [9:0]  ms_cnt;    // milliseconds inside a second

	// millisecond divider
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cyc_cnt <= 16'h0000;
			tick_ms <= 1'b0;
		end else if (cyc_cnt == 16'(TICK_DIV - 1)) begin
			cyc_cnt <= 16'h0000;
			tick_ms <= 1'b1;
		end else begin
			cyc_cnt <= cyc_cnt + 16'h0001;
			tick_ms <= 1'b0;
		end
	end

	// second divider, counts millisecond ticks
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ms_cnt <= 10'h000;
			tick_s <= 1'b0;
		end else if (cyc_cnt == 16'(TICK_DIV - 1) && ms_cnt == 10'(MS_PER_S - 1)) begin
			ms_cnt <= 10'h000;
			tick_s <= 1'b1;
		end else begin
			if (cyc_cnt == 16'(TICK_DIV - 1))
				ms_cnt <= ms_cnt + 10'h001;
			tick_s <= 1'b0;
		end
	end

endmodule : pos_tick

/* File: verilog/pos_seq.sv */
// Purpose: presence output sequencer: motion events to switch telegrams
// Assumes: motion input is asynchronous; cfg is static, tel_ready from mclk logic
// Notes:   time limits are clamped; seconds count at one-second ticks
`timescale 1ns/1ns
module pos_seq
	import pos_pkg::*;
#(
	parameter int TICK_DIV = CYC_PER_MS  // cycles per millisecond; lower only to shorten runs
)
(
	// clock and reset
	input  wire logic     mclk,
	input  wire logic     rstn,
	// configuration
	input  wire pos_cfg_t cfg,
	// sensor side
	input  wire logic     motion,     // raw detector level, async
	// telegram output
	output pos_tel_t      tel,        // registered telegram content
	output logic          tel_valid,  // telegram pending
	input  wire logic     tel_ready,  // bus side takes the telegram
	// status
	output logic          light_on,   // output currently in on, hold or a stage
	output logic [1:0]    stage       // 0 none, 1 A, 2 B, 3 C
);

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	typedef enum logic [2:0] {
		S_IDLE,    // off, detection armed
		S_ON,      // motion present
		S_HOLD,    // light-on delay running
		S_STG_A,
		S_STG_B,
		S_STG_C,
		S_SAFE     // safety time, detection ignored
	} pos_state_t;

	pos_state_t  state;        // sequencer state
	logic        mot_m;        // synchroniser first stage
	logic        mot_s;        // synchronised motion
	logic        tick_ms;      // one-millisecond pulse
	logic        tick_s;       // one-second pulse
	logic [15:0] tmr;          // state timer, seconds or ms
	logic [15:0] cyc_tmr;      // cyclic repeat timer, seconds
	logic        cyc_en;       // current value repeats
	logic [15:0] light_lim;    // clamped light-on delay
	logic [15:0] safe_lim;     // clamped safety time
	logic [15:0] cyc_lim;      // clamped cyclic period
	logic [15:0] stay_lim [3]; // clamped stage stay times

	// -----------------------------------------------------------------
	// time base and clamping
	// -----------------------------------------------------------------
	pos_tick #(
		.TICK_DIV (TICK_DIV)
	) pos_tick_i (
		.mclk    (mclk),
		.rstn    (rstn),
		.tick_ms (tick_ms),
		.tick_s  (tick_s)
	);

	// out-of-range settings are pulled to the nearest limit, not rejected
	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
	                                     input logic [15:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp

	assign light_lim   = clamp(cfg.light_s, LIGHT_MIN_S, TIME_MAX_S);
	assign safe_lim    = clamp(cfg.safe_ms, SAFE_MIN_MS, SAFE_MAX_MS);
	assign cyc_lim     = clamp(cfg.cyc_s, CYC_MIN_S, TIME_MAX_S);
	assign stay_lim[0] = clamp(cfg.stay_a_s, STAGE_MIN_S, TIME_MAX_S);
	assign stay_lim[1] = clamp(cfg.stay_b_s, STAGE_MIN_S, TIME_MAX_S);
	assign stay_lim[2] = clamp(cfg.stay_c_s, STAGE_MIN_S, TIME_MAX_S);

	// -----------------------------------------------------------------
	// motion synchroniser
	// -----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mot_m <= 1'b0;
			mot_s <= 1'b0;
		end else begin
			mot_m <= motion;
			mot_s <= mot_m;
		end
	end

	// -----------------------------------------------------------------
	// send requests
	// -----------------------------------------------------------------
	logic       send_req;   // a telegram is to be queued this cycle
	logic [7:0] send_val;   // its raw value
	logic       send_cyc;   // whether it repeats afterwards
	pos_state_t next_state; // state after this cycle
	logic       tmr_load;   // restart state timer
	logic       tmr_done;   // state timer reached its limit
	logic [15:0] tmr_lim;   // limit for the current state

	// limit for the running timer; safety counts in ms, the rest in s
	always_comb begin
		unique case (state)
			S_HOLD:  tmr_lim = light_lim;
			S_STG_A: tmr_lim = stay_lim[0];
			S_STG_B: tmr_lim = stay_lim[1];
			S_STG_C: tmr_lim = stay_lim[2];
			S_SAFE:  tmr_lim = safe_lim;
			default: tmr_lim = TIME_MAX_S;
		endcase
	end

	assign tmr_done = (tmr >= tmr_lim);

	// next state and telegram decision
	always_comb begin
		next_state = state;
		send_req   = 1'b0;
		send_val   = LEVEL_OFF;
		send_cyc   = 1'b0;
		tmr_load   = 1'b0;
		unique case (state)
			S_IDLE: begin
				if (mot_s) begin
					next_state = S_ON;
					send_req   = (cfg.send_sel != POS_SEND_OFF);
					send_val   = cfg.on_val;
					send_cyc   = cfg.on_cyclic;
				end
			end
			S_ON: begin
				if (!mot_s) begin
					next_state = S_HOLD;
					tmr_load   = 1'b1;
				end
			end
			S_HOLD: begin
				if (mot_s) begin
					next_state = S_ON;
				end else if (tmr_done) begin
					tmr_load = 1'b1;
					if (cfg.three_stage) begin
						next_state = S_STG_A;
						send_req   = 1'b1;
						send_val   = cfg.lvl_a;
					end else begin
						next_state = S_SAFE;
						send_req   = (cfg.send_sel != POS_SEND_ON);
						send_val   = cfg.off_val;
						send_cyc   = cfg.off_cyclic;
					end
				end
			end
			S_STG_A, S_STG_B, S_STG_C: begin
				if (mot_s) begin
					next_state = S_ON;
					send_req   = (cfg.send_sel != POS_SEND_OFF);
					send_val   = cfg.on_val;
					send_cyc   = cfg.on_cyclic;
				end else if (tmr_done) begin
					tmr_load = 1'b1;
					send_req = 1'b1;
					if (state == S_STG_A) begin
						next_state = S_STG_B;
						send_val   = cfg.lvl_b;
					end else if (state == S_STG_B) begin
						next_state = S_STG_C;
						send_val   = cfg.lvl_c;
					end else begin
						next_state = S_SAFE;
						send_req   = (cfg.send_sel != POS_SEND_ON);
						send_val   = cfg.off_val;
						send_cyc   = cfg.off_cyclic;
					end
				end
			end
			S_SAFE: begin
				if (tmr_done)
					next_state = S_IDLE;
			end
			default: next_state = S_IDLE;
		endcase
	end

	// -----------------------------------------------------------------
	// state and timers
	// -----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			state <= S_IDLE;
		else
			state <= next_state;
	end

	// state timer; safety ticks in ms, everything else in seconds
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			tmr <= 16'h0000;
		else if (tmr_load)
			tmr <= 16'h0000;
		else if (((state == S_SAFE) ? tick_ms : tick_s) && !tmr_done)
			tmr <= tmr + 16'h0001;
	end

	// a switch event ends the old value's repeat even when send_sel keeps it quiet;
	// hold and the return to idle keep the current value repeating
	logic sw_event; // switch-on or switch-off event this cycle
	assign sw_event = (next_state != state) &&
	                  ((next_state == S_ON && state != S_HOLD) || (next_state == S_SAFE));

	// cyclic repeat; any new value replaces and restarts it
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cyc_en  <= 1'b0;
			cyc_tmr <= 16'h0000;
		end else if (send_req || sw_event) begin
			cyc_en  <= send_req && send_cyc;
			cyc_tmr <= 16'h0000;
		end else if (cyc_en && tick_s) begin
			cyc_tmr <= (cyc_tmr + 16'h0001 >= cyc_lim) ? 16'h0000 : cyc_tmr + 16'h0001;
		end
	end

	// -----------------------------------------------------------------
	// telegram register
	// -----------------------------------------------------------------
	logic cyc_fire; // period elapsed on a repeating value
	assign cyc_fire = cyc_en && tick_s && (cyc_tmr + 16'h0001 >= cyc_lim) && !send_req;

	// a pending telegram is overwritten by a newer one: only the latest value matters
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tel       <= '0;
			tel_valid <= 1'b0;
		end else if (send_req) begin
			tel.byte_mode <= cfg.byte_mode;
			tel.value     <= cfg.byte_mode ? send_val : {7'h00, send_val[0]};
			tel_valid     <= 1'b1;
		end else if (cyc_fire) begin
			tel_valid <= 1'b1;
		end else if (tel_ready) begin
			tel_valid <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// status
	// -----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			light_on <= 1'b0;
			stage    <= 2'h0;
		end else begin
			light_on <= (next_state != S_IDLE) && (next_state != S_SAFE);
			stage    <= (next_state == S_STG_A) ? 2'h1 :
			            (next_state == S_STG_B) ? 2'h2 :
			            (next_state == S_STG_C) ? 2'h3 : 2'h0;
		end
	end

endmodule : pos_seq

/* File: tb/pos_seq_props.sv */
// Purpose: port checker for the presence output sequencer
// Assumes: cfg is static while a sequence runs
// Notes:   stage and expiry checks need seconds of mclk to be reached
`timescale 1ns/1ns
module pos_seq_props
	import pos_pkg::*;
(
	// clock and reset
	input wire logic       mclk,
	input wire logic       rstn,
	// configuration and sensor
	input wire pos_cfg_t   cfg,
	input wire logic       motion,
	// telegram link
	input wire pos_tel_t   tel,
	input wire logic       tel_valid,
	input wire logic       tel_ready,
	// status
	input wire logic       light_on,
	input wire logic [1:0] stage
);
	// -----------------------------------------------------------------
	// expected codes
	// -----------------------------------------------------------------
	logic [7:0] on_enc;   // switch-on value at configured width
	logic [7:0] off_enc;  // switch-off value at configured width
	logic [7:0] lvl_raw;  // byte level of the stage now shown
	logic [7:0] lvl_cur;  // that level at configured width
	assign on_enc  = cfg.byte_mode ? cfg.on_val : {7'h00, cfg.on_val[0]};
	assign off_enc = cfg.byte_mode ? cfg.off_val : {7'h00, cfg.off_val[0]};
	assign lvl_raw = (stage == 2'd1) ? cfg.lvl_a : (stage == 2'd2) ? cfg.lvl_b : cfg.lvl_c;
	assign lvl_cur = cfg.byte_mode ? lvl_raw : {7'h00, lvl_raw[0]};

	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	width_match_a: assert property (tel_valid |-> tel.byte_mode == cfg.byte_mode)
		else $error("telegram width differs from config");
	bit_clean_a: assert property (tel_valid && !cfg.byte_mode |-> tel.value[7:1] == 7'h00)
		else $error("upper bits set in 1-bit telegram");
	on_sent_a: assert property ($rose(light_on) && stage == 2'd0 &&
		cfg.send_sel != POS_SEND_OFF |-> tel_valid && tel.value == on_enc)
		else $error("switch-on telegram missing or wrong");
	on_quiet_a: assert property ($rose(light_on) && cfg.send_sel == POS_SEND_OFF &&
		!$past(tel_valid) |-> !tel_valid)
		else $error("switch-on telegram sent when excluded");
	valid_hold_a: assert property (tel_valid && !tel_ready |=> tel_valid)
		else $error("telegram dropped before it was taken");
	stage_lvl_a: assert property (stage != $past(stage) && stage != 2'd0
		|-> tel_valid && tel.value == lvl_cur)
		else $error("stage entry level wrong");
	step_order_a: assert property (stage != $past(stage) && stage != 2'd0
		|-> stage == $past(stage) + 2'd1)
		else $error("stage order broken");
	off_sent_a: assert property ($fell(light_on) && cfg.send_sel != POS_SEND_ON
		|-> tel_valid && tel.value == off_enc)
		else $error("switch-off telegram missing or wrong");
	no_stage_a: assert property (!cfg.three_stage |-> stage == 2'd0)
		else $error("stage entered with three-stage off disabled");
	safety_gap_a: assert property ($fell(light_on) |=> (!light_on) [*8])
		else $error("reactivated inside safety time");
endmodule : pos_seq_props

bind pos_seq pos_seq_props pos_seq_props_i (.mclk(mclk), .rstn(rstn), .cfg(cfg),
	.motion(motion), .tel(tel), .tel_valid(tel_valid), .tel_ready(tel_ready),
	.light_on(light_on), .stage(stage));

/* File: tb/pos_actuator.sv */
// Purpose: bus actuator model taking presence telegrams
// Assumes: lag sets cycles of stall before accepting
// Notes:   records the count and the last telegram taken
`timescale 1ns/1ns
module pos_actuator
	import pos_pkg::*;
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rstn,
	// telegram link
	input  wire pos_tel_t   tel,
	input  wire logic       tel_valid,
	output logic            tel_ready,
	// pacing and record
	input  wire logic [3:0] lag,
	output logic [7:0]      n_rx,
	output pos_tel_t        last
);
	logic [3:0] waited;  // cycles stalled on the pending telegram

	// -----------------------------------------------------------------
	// accept after lag cycles; ready drops right after each take
	// -----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tel_ready <= 1'b0;
			waited    <= 4'h0;
			n_rx      <= 8'h00;
			last      <= '0;
		end else begin
			if (tel_valid && tel_ready) begin
				n_rx <= n_rx + 8'h01;
				last <= tel;
			end
			tel_ready <= tel_valid && !tel_ready && waited >= lag;
			waited    <= (tel_valid && !tel_ready) ? waited + 4'h1 : 4'h0;
		end
	end
endmodule : pos_actuator

/* File: tb/pos_seq_tb_top.sv */
// Purpose: self-checking bench for the presence output sequencer
// Assumes: the design runs one cycle per millisecond, so a second is 1000 cycles
// Notes:   each case resets, so cfg only changes while idle
`timescale 1ns/1ns
module pos_seq_tb_top
	import pos_pkg::*;
;
	// -----------------------------------------------------------------
	// signals
	// -----------------------------------------------------------------
	logic       mclk;        // 10 MHz clock
	logic       rstn;        // active-low reset
	pos_cfg_t   cfg;         // configuration under test
	logic       motion;      // detector level
	pos_tel_t   tel;         // telegram from design
	logic       tel_valid;   // telegram pending
	logic       tel_ready;   // actuator takes
	logic       light_on;    // output on
	logic [1:0] stage;       // three-stage state
	logic [3:0] lag;         // actuator stall
	logic [7:0] n_rx;        // telegrams taken
	pos_tel_t   last;        // last taken
	int         err_total;   // mismatches
	int         n_compared;  // comparisons
	int         cycles;      // timeout count

	// one cycle per millisecond shrinks every timer so stages and safety fit the run
	pos_seq #(.TICK_DIV(1)) pos_seq_i (.mclk(mclk), .rstn(rstn), .cfg(cfg), .motion(motion), .tel(tel),
		.tel_valid(tel_valid), .tel_ready(tel_ready), .light_on(light_on), .stage(stage));
	pos_actuator pos_actuator_i (.mclk(mclk), .rstn(rstn), .tel(tel), .tel_valid(tel_valid),
		.tel_ready(tel_ready), .lag(lag), .n_rx(n_rx), .last(last));

	// -----------------------------------------------------------------
	// tasks
	// -----------------------------------------------------------------
	task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	// one motion episode; cyclic repeat cannot come within a second
	task automatic run_case(input pos_send_t sel, input logic bm, input logic [7:0] v,
		input logic [3:0] lg);
		logic [8:0] want;
		logic [8:0] n_want;
		want   = {bm, bm ? v : {7'h00, v[0]}};
		n_want = (sel == POS_SEND_OFF) ? 9'h000 : 9'h001;
		rstn = 1'b0;
		cfg.send_sel = sel;
		cfg.byte_mode = bm;
		cfg.on_val = v;
		lag = lg;
		repeat (2) @(negedge mclk);
		rstn = 1'b1;
		check({5'h00, tel_valid, light_on, stage}, 9'h000, "idle state");
		motion = 1'b1;
		repeat (20) @(negedge mclk);
		check({8'h00, light_on}, 9'h001, "light on");
		check({1'b0, n_rx}, n_want, "on count");
		if (n_want != 9'h000)
			check(last, want, "on value");
		motion = 1'b0;
		repeat (60) @(negedge mclk);
		check({8'h00, light_on}, 9'h001, "hold on");
		check({1'b0, n_rx}, n_want, "no early off");
		motion = 1'b1;
		repeat (20) @(negedge mclk);
		check({1'b0, n_rx}, n_want, "renewed motion");
		motion = 1'b0;
	endtask : run_case

	// scaled episode: stages, off value and its repeat, then motion inside stage A
	task automatic run_long();
		rstn = 1'b0;
		cfg.send_sel = POS_SEND_BOTH;
		cfg.byte_mode = 1'b1;
		cfg.on_val = LEVEL_FULL;
		cfg.on_cyclic = 1'b0;
		cfg.off_cyclic = 1'b1;
		cfg.lvl_a = LEVEL_99;
		lag = 4'h2;
		repeat (2) @(negedge mclk);
		rstn = 1'b1;
		motion = 1'b1;
		repeat (20) @(negedge mclk);
		motion = 1'b0;
		repeat (10200) @(negedge mclk);
		check({7'h00, stage}, 9'h001, "stage A");
		check({1'b0, n_rx}, 9'h002, "stage A sent");
		check(last, {1'b1, LEVEL_99}, "stage A level");
		repeat (5000) @(negedge mclk);
		check({7'h00, stage}, 9'h002, "stage B");
		check({1'b0, n_rx}, 9'h003, "stage B sent");
		check(last, {1'b1, cfg.lvl_b}, "stage B level");
		repeat (5000) @(negedge mclk);
		check({7'h00, stage}, 9'h003, "stage C");
		check(last, {1'b1, cfg.lvl_c}, "stage C level");
		repeat (5100) @(negedge mclk);
		check({6'h00, light_on, stage}, 9'h000, "off after C");
		check({1'b0, n_rx}, 9'h005, "off sent");
		check(last, {1'b1, LEVEL_OFF}, "off value");
		repeat (10000) @(negedge mclk);
		check({1'b0, n_rx}, 9'h006, "off repeated");
		motion = 1'b1;
		repeat (20) @(negedge mclk);
		check({light_on, n_rx}, 9'h107, "on after safety");
		check(last, {1'b1, LEVEL_FULL}, "on value again");
		motion = 1'b0;
		repeat (10200) @(negedge mclk);
		check({1'b0, n_rx}, 9'h008, "second stage A");
		motion = 1'b1;
		repeat (20) @(negedge mclk);
		check({6'h00, light_on, stage}, 9'h004, "motion in stage");
		check({1'b0, n_rx}, 9'h009, "on from stage");
		check(last, {1'b1, LEVEL_FULL}, "on value from stage");
		motion = 1'b0;
	endtask : run_long

	// -----------------------------------------------------------------
	// clock, timeout, main sequence
	// -----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 50000) begin // tests need about 46000 cycles
			err_total++;
			wrap_up();
		end
	end

	initial begin
		err_total = 0;
		n_compared = 0;
		cycles = 0;
		rstn = 1'b0;
		motion = 1'b0;
		lag = 4'h0;
		cfg = '0;
		cfg.on_cyclic = 1'b1;
		cfg.cyc_s = CYC_MIN_S;
		cfg.three_stage = 1'b1;
		cfg.stay_a_s = STAGE_MIN_S;
		cfg.stay_b_s = STAGE_MIN_S;
		cfg.stay_c_s = STAGE_MIN_S;
		cfg.lvl_a = LEVEL_FULL;
		cfg.lvl_b = 8'h08;
		cfg.lvl_c = 8'h03;
		cfg.light_s = LIGHT_MIN_S;
		cfg.safe_ms = SAFE_MIN_MS;
		repeat (16) @(negedge mclk);
		run_case(POS_SEND_BOTH, 1'b1, LEVEL_FULL, 4'h0);
		run_case(POS_SEND_ON, 1'b1, LEVEL_99, 4'h5);
		run_case(POS_SEND_OFF, 1'b1, LEVEL_FULL, 4'h0);
		run_case(POS_SEND_BOTH, 1'b0, 8'hff, 4'h3);
		run_case(POS_SEND_ON, 1'b0, 8'h00, 4'h0);
		run_long();
		wrap_up();
	end
endmodule : pos_seq_tb_top
